/* core/lpt_top.sv */
// Lamp pulse timing: pixel counter, lamp registers, four lamp outputs.
// Assumes pclk is the pixel-rate clock and line_start marks each line.
// Registers are reached over APB; lamp registers live on page 3.
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/1ns

// Overview of operation
// - Lamp goes high at its on count
// - On count: high nibble plus low byte
// - Lamp goes low at its off count
// - Combine bit ORs shift pulse into lamp
// - Page register selects page; lamps on 3
// - Infrared off low byte resets to 0x30
module lpt_top #(
  parameter int unsigned ADDR_W = 12,
  parameter int unsigned CNT_W  = lpt_pkg::LPT_CNT_W
) (
  // Clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // APB register bus
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Line timing
  input  wire logic              line_start,
  input  wire logic              shift_pulse,
  // Lamp drivers
  output logic                   red_lamp_out,
  output logic                   green_lamp_out,
  output logic                   blue_lamp_out,
  output logic                   infrared1_lamp_out
);

  // Register path between bus responder and register file
  lpt_reg_if rif ();

  // Lamp register storage, one byte per index, only kept bits stored
  logic [7:0] regs_r   [lpt_pkg::LPT_NUM_REGS];
  logic [7:0] regs_nxt [lpt_pkg::LPT_NUM_REGS];

  // Pixel position within the current line
  logic [CNT_W-1:0] pix_cnt_r;
  logic [CNT_W-1:0] pix_cnt_nxt;

  // Per-lamp decoded timing
  logic [CNT_W-1:0] on_cnt   [lpt_pkg::LPT_NUM_LAMPS];
  logic [CNT_W-1:0] off_cnt  [lpt_pkg::LPT_NUM_LAMPS];
  logic             combine  [lpt_pkg::LPT_NUM_LAMPS];
  logic [lpt_pkg::LPT_NUM_LAMPS-1:0] lamp_vec; // Lamp flops, red first

  // Write slot decoded once from the bus index
  logic [3:0] wr_slot;
  logic [3:0] rd_slot;

  // Bus responder; owns the page register and the handshake
  lpt_apb_slave #(
    .ADDR_W (ADDR_W)
  ) u_apb (
    .pclk    (pclk),
    .presetn (presetn),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .paddr   (paddr),
    .pwdata  (pwdata),
    .prdata  (prdata),
    .pready  (pready),
    .pslverr (pslverr),
    .rif     (rif.bus)
  );

  // Slot lookup for both directions
  always_comb begin
    wr_slot = lpt_pkg::lpt_slot(rif.wr_idx);
    rd_slot = lpt_pkg::lpt_slot(rif.rd_idx);
  end

  // Read lookup; reserved bits are never stored, so they read zero
  always_comb begin
    if (lpt_pkg::lpt_is_lamp(rif.rd_idx)) begin
      rif.rd_data = regs_r[rd_slot];
    end else begin
      rif.rd_data = 8'h00;
    end
  end

  // Register file next values
  // Reserved bits are dropped on write; software is asked to keep
  // them zero, and the block does not depend on it.
  always_comb begin
    for (int i = 0; i < lpt_pkg::LPT_NUM_REGS; i++) begin
      regs_nxt[i] = regs_r[i];
    end
    if (rif.wr_en) begin
      // Only lamp indices reach here on the lamp page
      regs_nxt[wr_slot] = rif.wr_data
                          & lpt_pkg::lpt_wr_mask(wr_slot);
    end
  end

  // Register file flops; reset values from the shared table
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < lpt_pkg::LPT_NUM_REGS; i++) begin
        regs_r[i] <= lpt_pkg::LPT_RST_TABLE[i];
      end
    end else begin
      for (int i = 0; i < lpt_pkg::LPT_NUM_REGS; i++) begin
        regs_r[i] <= regs_nxt[i];
      end
    end
  end

  // Pixel counter next value
  // Saturates rather than wraps, so a long line never retriggers lamps
  always_comb begin
    if (line_start) begin
      pix_cnt_nxt = '0;
    end else if (pix_cnt_r != '1) begin
      pix_cnt_nxt = pix_cnt_r + 1'b1;
    end else begin
      pix_cnt_nxt = pix_cnt_r;
    end
  end

  // Pixel counter flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pix_cnt_r <= '0;
    end else begin
      pix_cnt_r <= pix_cnt_nxt;
    end
  end

  // Decode each lamp's four registers into counts and combine flag
  always_comb begin
    for (int l = 0; l < lpt_pkg::LPT_NUM_LAMPS; l++) begin
      // High nibble from bits 3..0, low byte whole
      on_cnt[l] = CNT_W'({
        regs_r[l*lpt_pkg::LPT_REGS_PER_LMP
               + lpt_pkg::LPT_SLOT_ON_HI][3:0],
        regs_r[l*lpt_pkg::LPT_REGS_PER_LMP
               + lpt_pkg::LPT_SLOT_ON_LO]});
      off_cnt[l] = CNT_W'({
        regs_r[l*lpt_pkg::LPT_REGS_PER_LMP
               + lpt_pkg::LPT_SLOT_OFF_HI][3:0],
        regs_r[l*lpt_pkg::LPT_REGS_PER_LMP
               + lpt_pkg::LPT_SLOT_OFF_LO]});
      combine[l] = regs_r[l*lpt_pkg::LPT_REGS_PER_LMP
                          + lpt_pkg::LPT_SLOT_ON_HI]
                         [lpt_pkg::LPT_COMBINE_BIT];
    end
  end

  // One pulse generator per lamp, red, green, blue, infrared
  for (genvar g = 0; g < lpt_pkg::LPT_NUM_LAMPS; g++) begin : g_lamp
    lpt_lamp_chan #(
      .CNT_W (CNT_W)
    ) u_chan (
      .pclk        (pclk),
      .presetn     (presetn),
      .pix_cnt     (pix_cnt_r),
      .on_cnt      (on_cnt[g]),
      .off_cnt     (off_cnt[g]),
      .combine     (combine[g]),
      .shift_pulse (shift_pulse),
      .lamp_out    (lamp_vec[g])
    );
  end

  // Lamp pins, each a channel flop without further logic
  always_comb begin
    red_lamp_out       = lamp_vec[0];
    green_lamp_out     = lamp_vec[1];
    blue_lamp_out      = lamp_vec[2];
    infrared1_lamp_out = lamp_vec[3];
  end

endmodule

/* core/lpt_pkg.sv */
// Constants, types and helpers shared by the lamp pulse timing block.
// Assumes 8-bit registers reached by a 5-bit register index, page 3.
package lpt_pkg;

  // Pixel counter width; lamp counts are the same width
  localparam int unsigned LPT_CNT_W        = 12;
  localparam int unsigned LPT_NUM_LAMPS    = 4;
  localparam int unsigned LPT_REGS_PER_LMP = 4;
  localparam int unsigned LPT_NUM_REGS     = 16;

  // Register indices; byte address is four times the index
  localparam logic [4:0] LPT_IDX_RED_ON_HI  = 5'h0B;
  localparam logic [4:0] LPT_IDX_RED_ON_LO  = 5'h0C;
  localparam logic [4:0] LPT_IDX_RED_OFF_HI = 5'h0D;
  localparam logic [4:0] LPT_IDX_RED_OFF_LO = 5'h0E;
  localparam logic [4:0] LPT_IDX_GRN_ON_HI  = 5'h0F;
  localparam logic [4:0] LPT_IDX_GRN_ON_LO  = 5'h10;
  localparam logic [4:0] LPT_IDX_GRN_OFF_HI = 5'h11;
  localparam logic [4:0] LPT_IDX_GRN_OFF_LO = 5'h12;
  localparam logic [4:0] LPT_IDX_BLU_ON_HI  = 5'h13;
  localparam logic [4:0] LPT_IDX_BLU_ON_LO  = 5'h14;
  localparam logic [4:0] LPT_IDX_BLU_OFF_HI = 5'h15;
  localparam logic [4:0] LPT_IDX_BLU_OFF_LO = 5'h16;
  localparam logic [4:0] LPT_IDX_IR1_ON_HI  = 5'h17;
  localparam logic [4:0] LPT_IDX_IR1_ON_LO  = 5'h18;
  localparam logic [4:0] LPT_IDX_IR1_OFF_HI = 5'h19;
  localparam logic [4:0] LPT_IDX_IR1_OFF_LO = 5'h1A;
  localparam logic [4:0] LPT_IDX_PAGE       = 5'h1F;
  localparam logic [4:0] LPT_IDX_FIRST      = LPT_IDX_RED_ON_HI;
  localparam logic [4:0] LPT_IDX_LAST       = LPT_IDX_IR1_OFF_LO;

  // Page selection
  localparam logic [7:0] LPT_LAMP_PAGE = 8'h03;
  localparam logic [7:0] LPT_PAGE_RST  = 8'h00;

  // Field positions and writable masks
  localparam int unsigned LPT_COMBINE_BIT = 4;
  localparam logic [7:0]  LPT_ON_HI_MASK  = 8'h1F;
  localparam logic [7:0]  LPT_OFF_HI_MASK = 8'h0F;
  localparam logic [7:0]  LPT_FULL_MASK   = 8'hFF;

  // Slot within a lamp group of four registers
  localparam logic [1:0] LPT_SLOT_ON_HI  = 2'h0;
  localparam logic [1:0] LPT_SLOT_ON_LO  = 2'h1;
  localparam logic [1:0] LPT_SLOT_OFF_HI = 2'h2;
  localparam logic [1:0] LPT_SLOT_OFF_LO = 2'h3;

  // Values after reset, in index order from the first lamp register
  localparam logic [7:0] LPT_RST_TABLE [LPT_NUM_REGS] = '{
    8'h00, 8'h11, 8'h03, 8'h06,
    8'h00, 8'h12, 8'h03, 8'h00,
    8'h00, 8'h13, 8'h03, 8'h30,
    8'h00, 8'h14, 8'h03, 8'h30};

  // Register bus responder states
  typedef enum logic [1:0] {
    LPT_ST_IDLE = 2'b01,
    LPT_ST_RESP = 2'b10
  } lpt_apb_st_type;

  // True for an index that holds lamp timing
  function automatic logic lpt_is_lamp(input logic [4:0] idx);
    return (idx >= LPT_IDX_FIRST) && (idx <= LPT_IDX_LAST);
  endfunction

  // Array slot of a lamp index
  function automatic logic [3:0] lpt_slot(input logic [4:0] idx);
    logic [4:0] d;
    d = idx - LPT_IDX_FIRST;
    return d[3:0];
  endfunction

  // Bits that hardware keeps for a slot; the rest read as zero
  function automatic logic [7:0] lpt_wr_mask(input logic [3:0] slot);
    logic [7:0] m;
    m = LPT_FULL_MASK;
    if (slot[1:0] == LPT_SLOT_ON_HI) begin
      m = LPT_ON_HI_MASK;
    end else if (slot[1:0] == LPT_SLOT_OFF_HI) begin
      m = LPT_OFF_HI_MASK;
    end
    return m;
  endfunction

endpackage

/* core/lpt_reg_if.sv */
// Register access path between the bus responder and the register file.
// Assumes both ends share pclk; all signals are single-cycle levels.
`timescale 1ns/1ns
interface lpt_reg_if;
  logic       wr_en;    // Write strobe, one cycle
  logic [4:0] wr_idx;   // Written register index
  logic [7:0] wr_data;  // Written byte
  logic [4:0] rd_idx;   // Looked-up register index
  logic [7:0] rd_data;  // Masked contents at rd_idx

  // Bus side issues accesses
  modport bus (output wr_en, output wr_idx, output wr_data,
               output rd_idx, input rd_data);
  // Register file side answers them
  modport regs (input wr_en, input wr_idx, input wr_data,
                input rd_idx, output rd_data);
endinterface

/* core/lpt_lamp_chan.sv */
// One lamp output: set at its on count, cleared at its off count.
// Assumes the pixel count restarts at every line start.
`timescale 1ns/1ns
module lpt_lamp_chan #(
  parameter int unsigned CNT_W = 12
) (
  // Clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // Timing inputs
  input  wire logic [CNT_W-1:0] pix_cnt,
  input  wire logic [CNT_W-1:0] on_cnt,
  input  wire logic [CNT_W-1:0] off_cnt,
  input  wire logic             combine,
  input  wire logic             shift_pulse,
  // Lamp drive
  output logic                  lamp_out
);

  logic pulse_r;    // Own on/off pulse
  logic pulse_nxt;
  logic lamp_nxt;

  // Off wins when both counts match, so equal counts give no pulse
  always_comb begin
    pulse_nxt = pulse_r;
    if (pix_cnt == off_cnt) begin
      pulse_nxt = 1'b0;
    end else if (pix_cnt == on_cnt) begin
      pulse_nxt = 1'b1;
    end
    lamp_nxt = pulse_nxt | (combine & shift_pulse);
  end

  // Registered so the lamp pin comes straight from a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pulse_r  <= 1'b0;
      lamp_out <= 1'b0;
    end else begin
      pulse_r  <= pulse_nxt;
      lamp_out <= lamp_nxt;
    end
  end

endmodule

/* core/lpt_apb_slave.sv */
// APB responder with the page register; one access cycle, no waits.
// Assumes an APB3 master; lamp registers are served through lpt_reg_if.
`timescale 1ns/1ns
module lpt_apb_slave #(
  parameter int unsigned ADDR_W = 12
) (
  // Clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // APB
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Register file path
  lpt_reg_if.bus                 rif
);

  lpt_pkg::lpt_apb_st_type st_r;    // Handshake state
  lpt_pkg::lpt_apb_st_type st_nxt;
  logic [7:0]  page_r;              // Selected register page
  logic [7:0]  page_nxt;
  logic [31:0] prdata_nxt;
  logic        pready_nxt;
  logic        pslverr_nxt;
  logic [4:0]  idx;                 // Word index of paddr
  logic        aligned;             // Inside the map and word aligned
  logic        lamp_hit;            // Lamp register on the lamp page
  logic        page_hit;            // Page register, any page
  logic        commit;              // Write edge of a good access

  // Address decode
  always_comb begin
    idx      = paddr[6:2];
    aligned  = (paddr[1:0] == 2'h0) && (paddr[ADDR_W-1:7] == '0);
    page_hit = aligned && (idx == lpt_pkg::LPT_IDX_PAGE);
    lamp_hit = aligned && (page_r == lpt_pkg::LPT_LAMP_PAGE)
               && lpt_pkg::lpt_is_lamp(idx);
  end

  // Next state, answer and page register
  always_comb begin
    st_nxt      = st_r;
    prdata_nxt  = prdata;
    pready_nxt  = 1'b0;
    pslverr_nxt = pslverr;
    page_nxt    = page_r;
    commit      = 1'b0;
    case (st_r)
      lpt_pkg::LPT_ST_IDLE: begin
        // Setup cycle: fetch read data and error now, answer next
        if (psel && !penable) begin
          st_nxt      = lpt_pkg::LPT_ST_RESP;
          pready_nxt  = 1'b1;
          pslverr_nxt = !(page_hit || lamp_hit);
          if (page_hit) begin
            prdata_nxt = {24'h000000, page_r};
          end else if (lamp_hit) begin
            prdata_nxt = {24'h000000, rif.rd_data};
          end else begin
            prdata_nxt = 32'h00000000;
          end
        end
      end
      lpt_pkg::LPT_ST_RESP: begin
        // Access cycle: writes land only on this edge
        st_nxt = lpt_pkg::LPT_ST_IDLE;
        commit = psel && penable && pwrite && !pslverr;
        if (commit && page_hit) begin
          page_nxt = pwdata[7:0];
        end
      end
      default: begin
        st_nxt = lpt_pkg::LPT_ST_IDLE;
      end
    endcase
  end

  // Register file write and lookup
  always_comb begin
    rif.wr_en   = commit && lamp_hit;
    rif.wr_idx  = idx;
    rif.wr_data = pwdata[7:0];
    rif.rd_idx  = idx;
  end

  // Handshake flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r    <= lpt_pkg::LPT_ST_IDLE;
      page_r  <= lpt_pkg::LPT_PAGE_RST;
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      st_r    <= st_nxt;
      page_r  <= page_nxt;
      prdata  <= prdata_nxt;
      pready  <= pready_nxt;
      pslverr <= pslverr_nxt;
    end
  end

endmodule

/* bench/lpt_lamp_model.sv */
// Lamp driver model: logs where each lamp turns on and off in a line.
// Assumes line_start is the same level the block sees.
`timescale 1ns/1ns
module lpt_lamp_model (
  // Clock and reset
  input wire logic       pclk,
  input wire logic       presetn,
  // Line and lamps
  input wire logic       line_start,
  input wire logic [3:0] lamp_in
);
  logic [11:0] pos;          // Pixel position seen by the drivers
  logic [3:0]  prev;         // Lamp levels one cycle back
  logic [11:0] rise_pos [4]; // Position of last turn-on
  logic [11:0] fall_pos [4]; // Position of last turn-off
  int          n_rise [4];   // Turn-ons in the current line
  // Log edges; a new line clears the counts
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pos  <= 12'h000;
      prev <= 4'h0;
    end else begin
      prev <= lamp_in;
      pos  <= line_start ? 12'h000 : pos + {11'h000, pos != 12'hFFF};
      for (int i = 0; i < 4; i++) begin
        if (line_start) begin
          n_rise[i] <= 0;
        end else if (lamp_in[i] && !prev[i]) begin
          rise_pos[i] <= pos;
          n_rise[i]   <= n_rise[i] + 1;
        end else if (!lamp_in[i] && prev[i]) begin
          fall_pos[i] <= pos;
        end
      end
    end
  end
endmodule

/* bench/lpt_top_props.sv */
// Port-level checks of the lamp timing block.
// Assumes the APB master holds each request until pready.
`timescale 1ns/1ns
module lpt_top_props #(
  parameter int unsigned ADDR_W = 12
) (
  // Clock and reset
  input wire logic              pclk,
  input wire logic              presetn,
  // APB
  input wire logic              psel,
  input wire logic              penable,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  // Lamps
  input wire logic              red_lamp_out,
  input wire logic              green_lamp_out,
  input wire logic              blue_lamp_out,
  input wire logic              infrared1_lamp_out
);
  logic setup_c; // Setup cycle of a transfer
  assign setup_c = psel & ~penable;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_ANSWER_NEXT: assert property (setup_c |=> pready)
    else $error("no answer after setup");
  AST_PREADY_ONE: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  AST_PREADY_CAUSE: assert property (!$past(setup_c) |-> !pready)
    else $error("pready without setup");
  AST_HIGH_ZERO: assert property (pready |-> prdata[31:8] == 24'h0)
    else $error("read data upper bytes set");
  AST_MISALIGNED: assert property (setup_c && paddr[1:0] != 2'h0
    |=> pready && pslverr) else $error("misaligned not refused");
  AST_UPPER_ADDR: assert property (setup_c && paddr[ADDR_W-1:7] != '0
    |=> pslverr) else $error("high address not refused");
  AST_PAGE_OPEN: assert property (setup_c && paddr[6:0] == 7'h7C
    && paddr[ADDR_W-1:7] == '0 |=> !pslverr) else $error("page reg refused");
  AST_RDATA_HOLD: assert property (!pready |-> $stable(prdata)
    && $stable(pslverr)) else $error("answer changed between accesses");
  AST_LAMPS_RESET: assert property ($rose(presetn) |-> !(red_lamp_out
    || green_lamp_out || blue_lamp_out || infrared1_lamp_out))
    else $error("lamp high right after reset");
endmodule
bind lpt_top lpt_top_props #(.ADDR_W(ADDR_W)) lpt_top_props_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .red_lamp_out(red_lamp_out), .green_lamp_out(green_lamp_out),
  .blue_lamp_out(blue_lamp_out), .infrared1_lamp_out(infrared1_lamp_out));

/* bench/tb.sv */
// Self-checking bench: registers over APB, lamp timing per line.
// Assumes a zero-wait APB responder and the lamp driver model.
`timescale 1ns/1ns
module tb;
  logic        pclk, presetn, psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic        pready, pslverr, line_start, shift_pulse;
  logic [3:0]  lamps;    // Red, green, blue, infrared from bit 0
  int n_errors, samples_checked;
  logic [7:0]  rd;       // Last read byte
  logic        er;       // Last error flag
  // Values after reset, first lamp register upward
  logic [7:0] rst_exp [16] = '{8'h00, 8'h11, 8'h03, 8'h06, 8'h00, 8'h12,
    8'h03, 8'h00, 8'h00, 8'h13, 8'h03, 8'h30, 8'h00, 8'h14, 8'h03, 8'h30};
  lpt_top lpt_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .line_start(line_start), .shift_pulse(shift_pulse),
    .red_lamp_out(lamps[0]), .green_lamp_out(lamps[1]),
    .blue_lamp_out(lamps[2]), .infrared1_lamp_out(lamps[3]));
  lpt_lamp_model lpt_lamp_model_inst (.pclk(pclk), .presetn(presetn),
    .line_start(line_start), .lamp_in(lamps));
  // 25 MHz clock
  always #20 pclk = ~pclk;
  // Comparison of one value
  task automatic chk(string nm, logic [11:0] ex, logic [11:0] got);
    samples_checked++;
    if (got !== ex) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, ex, got);
    end
  endtask
  // One APB transfer; entered just after a rising edge
  task automatic apb(logic w, logic [11:0] a, logic [7:0] d);
    int n;
    n = 0;
    psel <= 1'b1; penable <= 1'b0; pwrite <= w;
    paddr <= a; pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 16) begin
      @(posedge pclk);
      n++;
    end
    // A responder that never answers counts against the run
    if (pready !== 1'b1) begin
      n_errors++;
      $display("wrong value pready expected 1 seen %b", pready);
    end
    rd = prdata[7:0];
    er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge pclk);
  endtask
  // One line: start pulse, then enough pixels to pass every off count
  task automatic line();
    line_start <= 1'b1;
    @(posedge pclk);
    line_start <= 1'b0;
    repeat (300) @(posedge pclk);
  endtask
  // Page register gates the lamp registers
  task automatic t_page();
    apb(0, 12'h02C, 8'h00); chk("page0 lamp err", 1, er);
    apb(0, 12'h07C, 8'h00); chk("page reset", 0, rd);
    apb(1, 12'h07C, 8'h03);
    apb(0, 12'h07C, 8'h00); chk("page set", 3, rd);
  endtask
  // Reset values of every lamp register
  task automatic t_resets();
    for (int i = 0; i < 16; i++) begin
      apb(0, 12'((11 + i) * 4), 8'h00);
      chk("reset value", rst_exp[i], rd);
    end
  endtask
  // Unmapped, misaligned and out-of-range places are refused
  task automatic t_bad();
    logic [11:0] bad [3] = '{12'h06C, 12'h02D, 12'h82C};
    for (int i = 0; i < 3; i++) begin
      apb(0, bad[i], 8'h00); chk("refused", 1, er);
    end
  endtask
  // Twelve-bit on/off counts, repeated on two lines
  task automatic t_timing();
    logic [11:0] b;
    for (int i = 0; i < 4; i++) begin
      b = 12'((11 + 4 * i) * 4);
      apb(1, b, 8'h01);
      apb(1, b + 12'h4, 8'(2 + 4 * i));
      apb(1, b + 12'h8, 8'h01);
      apb(1, b + 12'hC, 8'(7 + 4 * i));
      apb(0, b + 12'h4, 8'h00); chk("on low", 8'(2 + 4 * i), rd);
    end
    // Lamps went on at their reset on count before the first line;
    // one settling line lets them fall before edges are logged
    line();
    for (int k = 0; k < 2; k++) begin
      line();
      for (int i = 0; i < 4; i++) begin
        chk("rise", 12'h103 + 12'(4 * i), lpt_lamp_model_inst.rise_pos[i]);
        chk("fall", 12'h108 + 12'(4 * i), lpt_lamp_model_inst.fall_pos[i]);
        chk("rises", 1, 12'(lpt_lamp_model_inst.n_rise[i]));
      end
    end
  endtask
  // Shift pulse reaches only a lamp with combining on
  task automatic t_combine();
    apb(1, 12'h02C, 8'h11);
    shift_pulse <= 1'b1;
    @(posedge pclk);
    shift_pulse <= 1'b0;
    #1 chk("red ored", 1, lamps[0]);
    chk("green plain", 0, lamps[1]);
    @(posedge pclk);
    #1 chk("red after", 0, lamps[0]);
  endtask
  // Verdict and end of run
  task automatic complete_run();
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0;
    paddr = 0; pwdata = 0; line_start = 0; shift_pulse = 0;
    n_errors = 0; samples_checked = 0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_page();
    t_resets();
    t_bad();
    t_timing();
    t_combine();
    complete_run();
  end
  // Watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge pclk);
    n_errors++;
    complete_run();
  end
endmodule
